// *** rtl/dsc_pkg.sv ***
// Constants, types and field layout for the converter's serial configuration port.
package dsc_pkg;

    localparam int DSC_AW = 5;
    localparam int DSC_DW = 8;
    localparam int DSC_NREG = 32;
    localparam int DSC_FIFO_DEPTH = 8;

    localparam logic [4:0] DSC_ADDR_SERIAL = 5'h00;
    localparam logic [4:0] DSC_ADDR_CLKDIV = 5'h03;
    localparam logic [4:0] DSC_ADDR_PLL = 5'h04;
    localparam logic [4:0] DSC_ADDR_I_FINE = 5'h05;
    localparam logic [4:0] DSC_ADDR_I_COARSE = 5'h06;
    localparam logic [4:0] DSC_ADDR_I_OFFH = 5'h07;
    localparam logic [4:0] DSC_ADDR_I_OFFL = 5'h08;
    localparam logic [4:0] DSC_ADDR_Q_FINE = 5'h09;
    localparam logic [4:0] DSC_ADDR_Q_COARSE = 5'h0a;
    localparam logic [4:0] DSC_ADDR_Q_OFFH = 5'h0b;
    localparam logic [4:0] DSC_ADDR_Q_OFFL = 5'h0c;

    localparam int DSC_BIT_BIDIR = 7;
    localparam int DSC_BIT_LSB = 6;
    localparam int DSC_BIT_PLL_EN = 7;
    localparam int DSC_BIT_CP_MAN = 6;
    localparam int DSC_BIT_OFF_DIR = 7;
    localparam int DSC_BIT_RW = 7;

    localparam logic [7:0] DSC_REG_RESET = 8'h00;
    localparam logic [2:0] DSC_LAST_BIT = 3'h7;

    // Writable bits per address; everything else stays zero.
    localparam logic [7:0] DSC_WMASK [DSC_NREG] = '{
        0: 8'hc0, 3: 8'h03, 4: 8'hc7, 5: 8'hff, 6: 8'h0f, 7: 8'hff, 8: 8'h83,
        9: 8'hff, 10: 8'h0f, 11: 8'hff, 12: 8'h83, default: 8'h00};

    // Serial clock limit expressed in core clock cycles per half period.
    localparam int DSC_SCLK_MAX_KHZ = 15000;
    localparam int DSC_CORE_KHZ = 200000;
    localparam int DSC_SCLK_HALF_CYC = (DSC_CORE_KHZ + 2 * DSC_SCLK_MAX_KHZ - 1)
        / (2 * DSC_SCLK_MAX_KHZ);

    typedef enum logic [1:0] {DSC_IDLE, DSC_INSTR, DSC_DATA} dsc_state_type;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] data;
    } dsc_wr_type;

endpackage

// *** rtl/dsc_serial_config_port.sv ***
// Serial configuration port with its register file and write FIFO.
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Write FIFO
// ****************************************************************
module dsc_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wrPtr_reg;
    logic [PW-1:0] rdPtr_reg;
    logic [PW:0] count_reg;
    wire logic doPush;
    wire logic doPop;

    assign inReady = (count_reg != (PW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData = mem_reg[rdPtr_reg];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (doPush)
                wrPtr_reg <= (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
            if (doPop)
                rdPtr_reg <= (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
            count_reg <= count_reg + (PW+1)'(doPush) - (PW+1)'(doPop);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (doPush)
            mem_reg[wrPtr_reg] <= inData;
    end
endmodule // dsc_fifo

// ****************************************************************
// Serial port and configuration registers
// ****************************************************************
module dsc_serial_config_port #(
    parameter int FIFO_DEPTH = dsc_pkg::DSC_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Serial pins, sampled on core_clk
    input wire logic serialClk,
    input wire logic chipSelectN,
    input wire logic serialDataIn,
    output logic serialDataIoOut,
    output logic serialDataIoOeB,
    output logic serialDataOut,
    output logic serialDataOutOeB,
    // Clock and PLL configuration
    output logic [1:0] clkDivRatio,
    output logic pllEnable,
    output logic chargePumpManual,
    output logic [2:0] chargePumpCode,
    // Channel gain and offset
    output logic [7:0] iFineGain,
    output logic [3:0] iCoarseGain,
    output logic [9:0] iOffset,
    output logic iOffsetToB,
    output logic [7:0] qFineGain,
    output logic [3:0] qCoarseGain,
    output logic [9:0] qOffset,
    output logic qOffsetToB
);
    import dsc_pkg::*;

    logic [7:0] cfg_reg [DSC_NREG];
    dsc_state_type state_reg;
    logic sclkPrev_reg;
    logic csPrev_reg;
    logic [2:0] bitCnt_reg;
    logic [1:0] bytesLeft_reg;
    logic isRead_reg;
    logic [4:0] addr_reg;
    logic [7:0] rxShift_reg;
    logic [7:0] txShift_reg;
    logic outBit_reg;
    logic ioOeB_reg;
    logic outOeB_reg;
    logic [2:0] cpCode_reg;

    wire logic bidir;
    wire logic lsbFirst;
    wire logic csFall;
    wire logic sclkRise;
    wire logic sclkFall;
    wire logic byteDone;
    wire logic instrDone;
    wire logic dataDone;
    wire logic [7:0] rxNext;
    wire logic [4:0] addrStep;
    wire logic readLoad;
    wire logic [4:0] loadAddr;
    wire logic readPhase;
    wire logic [2:0] cpCodeNext;
    wire logic pushReady;
    wire logic wrValid;
    wire logic wrReady;
    wire dsc_wr_type pushWord;
    wire dsc_wr_type wrWord;

    assign bidir = cfg_reg[DSC_ADDR_SERIAL][DSC_BIT_BIDIR];
    assign lsbFirst = cfg_reg[DSC_ADDR_SERIAL][DSC_BIT_LSB];

    // ****************************************************************
    // Serial framing
    // ****************************************************************
    assign csFall = csPrev_reg && !chipSelectN;
    assign sclkRise = serialClk && !sclkPrev_reg && !chipSelectN && (state_reg != DSC_IDLE);
    assign sclkFall = !serialClk && sclkPrev_reg && !chipSelectN && (state_reg == DSC_DATA)
        && isRead_reg;
    // The instruction arrives in the same order as data.
    assign rxNext = lsbFirst ? {serialDataIn, rxShift_reg[7:1]}
        : {rxShift_reg[6:0], serialDataIn};
    assign byteDone = sclkRise && (bitCnt_reg == DSC_LAST_BIT);
    assign instrDone = byteDone && (state_reg == DSC_INSTR);
    assign dataDone = byteDone && (state_reg == DSC_DATA);
    // Five-bit arithmetic gives the 1Fh/00h wrap in both directions.
    assign addrStep = lsbFirst ? addr_reg + 5'h01 : addr_reg - 5'h01;
    assign readLoad = (instrDone && rxNext[DSC_BIT_RW])
        || (dataDone && isRead_reg && (bytesLeft_reg != 2'h0));
    assign loadAddr = instrDone ? rxNext[4:0] : addrStep;
    assign readPhase = !chipSelectN && (state_reg == DSC_DATA) && isRead_reg;
    assign pushWord = '{addr: addr_reg, data: rxNext};
    assign cpCodeNext = cfg_reg[DSC_ADDR_PLL][DSC_BIT_CP_MAN]
        ? cfg_reg[DSC_ADDR_PLL][2:0] : {1'b0, cfg_reg[DSC_ADDR_CLKDIV][1:0]};

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclkPrev_reg <= 1'b0;
            csPrev_reg <= 1'b1;
        end
        else
        begin
            sclkPrev_reg <= serialClk;
            csPrev_reg <= chipSelectN;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= DSC_IDLE;
            bitCnt_reg <= 3'h0;
        end
        else if (chipSelectN)
            state_reg <= DSC_IDLE;
        else if (csFall)
        begin
            state_reg <= DSC_INSTR;
            bitCnt_reg <= 3'h0;
        end
        else if (sclkRise)
        begin
            bitCnt_reg <= bitCnt_reg + 3'h1;
            if (instrDone)
                state_reg <= DSC_DATA;
            else if (dataDone && (bytesLeft_reg == 2'h0))
                state_reg <= DSC_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxShift_reg <= 8'h00;
            isRead_reg <= 1'b0;
            bytesLeft_reg <= 2'h0;
            addr_reg <= 5'h00;
        end
        else if (sclkRise)
        begin
            rxShift_reg <= rxNext;
            if (instrDone)
            begin
                isRead_reg <= rxNext[DSC_BIT_RW];
                bytesLeft_reg <= rxNext[6:5];
                addr_reg <= rxNext[4:0];
            end
            else if (dataDone)
            begin
                bytesLeft_reg <= bytesLeft_reg - 2'h1;
                addr_reg <= addrStep;
            end
        end
    end

    // ****************************************************************
    // Read data and pin drive
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            txShift_reg <= 8'h00;
            outBit_reg <= 1'b0;
        end
        else if (readLoad)
            txShift_reg <= cfg_reg[loadAddr];
        else if (sclkFall)
        begin
            outBit_reg <= lsbFirst ? txShift_reg[0] : txShift_reg[7];
            txShift_reg <= lsbFirst ? {1'b0, txShift_reg[7:1]} : {txShift_reg[6:0], 1'b0};
        end
    end

    // Enables are active low: high means the pin floats.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ioOeB_reg <= 1'b1;
            outOeB_reg <= 1'b1;
        end
        else
        begin
            ioOeB_reg <= !(readPhase && bidir);
            outOeB_reg <= !(readPhase && !bidir);
        end
    end

    assign serialDataIoOut = outBit_reg;
    assign serialDataIoOeB = ioOeB_reg;
    assign serialDataOut = outBit_reg;
    assign serialDataOutOeB = outOeB_reg;

    // ****************************************************************
    // Register write path
    // ****************************************************************
    // Bytes queue here so a read load never collides with a register write;
    // a byte that meets a full queue is dropped, which only a far too fast host causes.
    dsc_fifo #(
        .WIDTH($bits(dsc_wr_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .inValid(dataDone && !isRead_reg),
        .inReady(pushReady),
        .inData(pushWord),
        .outValid(wrValid),
        .outReady(wrReady),
        .outData(wrWord)
    );
    assign wrReady = !readLoad;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < DSC_NREG; i++)
                cfg_reg[i] <= DSC_REG_RESET;
            cpCode_reg <= 3'h0;
        end
        else
        begin
            if (wrValid && wrReady)
                cfg_reg[wrWord.addr] <= wrWord.data & DSC_WMASK[wrWord.addr];
            cpCode_reg <= cpCodeNext;
        end
    end

    assign clkDivRatio = cfg_reg[DSC_ADDR_CLKDIV][1:0];
    assign pllEnable = cfg_reg[DSC_ADDR_PLL][DSC_BIT_PLL_EN];
    assign chargePumpManual = cfg_reg[DSC_ADDR_PLL][DSC_BIT_CP_MAN];
    assign chargePumpCode = cpCode_reg;
    assign iFineGain = cfg_reg[DSC_ADDR_I_FINE];
    assign qFineGain = cfg_reg[DSC_ADDR_Q_FINE];
    assign iCoarseGain = cfg_reg[DSC_ADDR_I_COARSE][3:0];
    assign qCoarseGain = cfg_reg[DSC_ADDR_Q_COARSE][3:0];
    assign iOffset = {cfg_reg[DSC_ADDR_I_OFFH], cfg_reg[DSC_ADDR_I_OFFL][1:0]};
    assign qOffset = {cfg_reg[DSC_ADDR_Q_OFFH], cfg_reg[DSC_ADDR_Q_OFFL][1:0]};
    assign iOffsetToB = cfg_reg[DSC_ADDR_I_OFFL][DSC_BIT_OFF_DIR];
    assign qOffsetToB = cfg_reg[DSC_ADDR_Q_OFFL][DSC_BIT_OFF_DIR];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_instr_addr;
        @(posedge core_clk) disable iff (!rst_b)
        instrDone |=> (state_reg == DSC_DATA) && (addr_reg == $past(rxNext[4:0]));
    endproperty
    a_instr_addr: assert property (p_instr_addr) else $error("Bad start address.");

    property p_count;
        @(posedge core_clk) disable iff (!rst_b)
        instrDone |=> bytesLeft_reg == $past(rxNext[6:5]);
    endproperty
    a_count: assert property (p_count) else $error("Bad byte count.");

    property p_dir;
        @(posedge core_clk) disable iff (!rst_b)
        instrDone |=> isRead_reg == $past(rxNext[7]);
    endproperty
    a_dir: assert property (p_dir) else $error("Bad direction.");

    property p_restart;
        @(posedge core_clk) disable iff (!rst_b)
        csFall |=> (state_reg == DSC_INSTR) && (bitCnt_reg == 3'h0);
    endproperty
    a_restart: assert property (p_restart) else $error("No restart.");

    property p_float;
        @(posedge core_clk) disable iff (!rst_b)
        chipSelectN [*2] |-> serialDataIoOeB && serialDataOutOeB;
    endproperty
    a_float: assert property (p_float) else $error("Pin driven while deselected.");

    property p_sdo_quiet;
        @(posedge core_clk) disable iff (!rst_b)
        bidir && $past(bidir) |-> serialDataOutOeB;
    endproperty
    a_sdo_quiet: assert property (p_sdo_quiet) else $error("Output pin driven.");

    property p_msb_step;
        @(posedge core_clk) disable iff (!rst_b)
        dataDone && !lsbFirst |=> addr_reg == $past(addr_reg) - 5'h01;
    endproperty
    a_msb_step: assert property (p_msb_step) else $error("Bad address step.");

    property p_write;
        @(posedge core_clk) disable iff (!rst_b)
        wrValid && wrReady |=> cfg_reg[$past(wrWord.addr)]
            == ($past(wrWord.data) & DSC_WMASK[$past(wrWord.addr)]);
    endproperty
    a_write: assert property (p_write) else $error("Write lost.");

    property p_write_soon;
        @(posedge core_clk) disable iff (!rst_b)
        dataDone && !isRead_reg && pushReady |-> ##[1:3] (wrValid && wrReady);
    endproperty
    a_write_soon: assert property (p_write_soon) else $error("Write late.");

    property p_reserved;
        @(posedge core_clk) disable iff (!rst_b)
        (cfg_reg[DSC_ADDR_I_OFFL] & ~DSC_WMASK[DSC_ADDR_I_OFFL]) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved bit set.");

    c_read: cover property (@(posedge core_clk) disable iff (!rst_b) readLoad ##[1:300] readLoad);
    c_write: cover property (@(posedge core_clk) disable iff (!rst_b) wrValid && wrReady);
    c_abort: cover property (@(posedge core_clk) disable iff (!rst_b)
        (state_reg == DSC_DATA) ##1 chipSelectN);
    c_lsb: cover property (@(posedge core_clk) disable iff (!rst_b) lsbFirst && dataDone);
endmodule // dsc_serial_config_port

`default_nettype wire

// *** tb/dsc_host_model.sv ***
// Serial master model that drives the configuration port from the host side.
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Host serial master
// ****************************************************************
module dsc_host_model (
    // Clock
    input wire logic core_clk,
    // Serial pins
    output logic serialClk,
    output logic chipSelectN,
    output logic serialDataIn,
    input wire logic serialDataIoOut,
    input wire logic serialDataIoOeB,
    input wire logic serialDataOut,
    input wire logic serialDataOutOeB
);
    // Eight core cycles per half period keeps the serial clock under 15 MHz.
    localparam int HALF = 8;
    logic hostBit;
    logic hostOe;
    logic outOeSeen;
    logic ioOeSeen;
    int bitCount;

    initial
    begin
        serialClk = 1'b0;
        chipSelectN = 1'b1;
        hostBit = 1'b0;
        hostOe = 1'b1;
        outOeSeen = 1'b0;
        ioOeSeen = 1'b0;
        bitCount = 0;
    end

    // A released line shows the inverse of its last value, so no stale bit passes.
    assign serialDataIn = !serialDataIoOeB ? serialDataIoOut : (hostOe ? hostBit : ~hostBit);

    always @(posedge core_clk)
    begin
        if (!serialDataOutOeB)
            outOeSeen = 1'b1;
        if (!serialDataIoOeB)
            ioOeSeen = 1'b1;
    end

    // Byte 0 of the frame is the instruction; a nonzero stopAfter cuts the cycle short.
    task automatic xfer(input logic [7:0] instr, input int nBytes, input logic [31:0] wData,
                        input bit lsb, input int stopAfter, output logic [31:0] rData);
        logic [39:0] frame;
        int nBits;
        int pos;
        frame = {wData, instr};
        nBits = (stopAfter > 0) ? stopAfter : 8 * (nBytes + 1);
        rData = 32'h0;
        bitCount = 0;
        outOeSeen = 1'b0;
        ioOeSeen = 1'b0;
        @(posedge core_clk);
        chipSelectN <= 1'b0;
        for (int b = 0; b < nBits; b++)
        begin
            pos = 8 * (b / 8) + (lsb ? b % 8 : 7 - b % 8);
            hostBit <= frame[pos];
            hostOe <= !(instr[7] && b >= 8);
            repeat (HALF) @(posedge core_clk);
            if (b >= 8)
                rData[pos - 8] = serialDataOutOeB ? serialDataIn : serialDataOut;
            serialClk <= 1'b1;
            bitCount++;
            repeat (HALF) @(posedge core_clk);
            serialClk <= 1'b0;
        end
        repeat (HALF) @(posedge core_clk);
        chipSelectN <= 1'b1;
        hostOe <= 1'b1;
        repeat (HALF) @(posedge core_clk);
    endtask
endmodule // dsc_host_model

`default_nettype wire

// *** tb/tb.sv ***
// Self-checking testbench for the serial configuration port.
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Testbench top
// ****************************************************************
module tb;
    import dsc_pkg::*;
    logic core_clk;
    logic rst_b;
    logic serialClk, chipSelectN, serialDataIn;
    logic serialDataIoOut, serialDataIoOeB, serialDataOut, serialDataOutOeB;
    logic [1:0] clkDivRatio;
    logic pllEnable, chargePumpManual, iOffsetToB, qOffsetToB;
    logic [2:0] chargePumpCode;
    logic [7:0] iFineGain, qFineGain;
    logic [3:0] iCoarseGain, qCoarseGain;
    logic [9:0] iOffset, qOffset;
    logic [31:0] rv;
    int mismatches = 0;
    int nTests = 0;

    dsc_serial_config_port uut (.core_clk(core_clk), .rst_b(rst_b), .serialClk(serialClk),
        .chipSelectN(chipSelectN), .serialDataIn(serialDataIn),
        .serialDataIoOut(serialDataIoOut), .serialDataIoOeB(serialDataIoOeB),
        .serialDataOut(serialDataOut), .serialDataOutOeB(serialDataOutOeB),
        .clkDivRatio(clkDivRatio), .pllEnable(pllEnable), .chargePumpManual(chargePumpManual),
        .chargePumpCode(chargePumpCode), .iFineGain(iFineGain), .iCoarseGain(iCoarseGain),
        .iOffset(iOffset), .iOffsetToB(iOffsetToB), .qFineGain(qFineGain),
        .qCoarseGain(qCoarseGain), .qOffset(qOffset), .qOffsetToB(qOffsetToB));

    dsc_host_model host (.core_clk(core_clk), .serialClk(serialClk),
        .chipSelectN(chipSelectN), .serialDataIn(serialDataIn),
        .serialDataIoOut(serialDataIoOut), .serialDataIoOeB(serialDataIoOeB),
        .serialDataOut(serialDataOut), .serialDataOutOeB(serialDataOutOeB));

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        nTests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [4:0] a, input int n, input logic [31:0] d, input bit lsb);
        logic [31:0] r;
        host.xfer({1'b0, 2'(n - 1), a}, n, d, lsb, 0, r);
    endtask

    task automatic rd(input logic [4:0] a, input int n, input bit lsb, output logic [31:0] r);
        host.xfer({1'b1, 2'(n - 1), a}, n, 32'h0, lsb, 0, r);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", nTests, mismatches);
        if (mismatches == 0 && nTests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        chk("config after reset", 64'h0, {clkDivRatio, pllEnable, chargePumpManual,
            chargePumpCode, iFineGain, iCoarseGain, iOffset, iOffsetToB, qFineGain,
            qCoarseGain, qOffset, qOffsetToB});
        chk("pin enables idle", 64'h3, {serialDataIoOeB, serialDataOutOeB});
    endtask

    // The first descending multibyte write also pushes all-ones into masked fields.
    task automatic t_gain_offset;
        wr(5'h08, 4, 32'h5aff3cff, 1'b0);
        chk("i fine", 64'h5a, iFineGain);
        chk("i coarse", 64'hf, iCoarseGain);
        chk("i offset", 64'h0f3, iOffset);
        chk("i to b", 64'h1, iOffsetToB);
        wr(5'h0c, 4, 32'ha500c302, 1'b0);
        chk("q fine", 64'ha5, qFineGain);
        chk("q coarse", 64'h0, qCoarseGain);
        chk("q offset", 64'h30e, qOffset);
        chk("q to b", 64'h0, qOffsetToB);
        rd(5'h08, 2, 1'b0, rv);
        chk("read 08 07", 64'h3c83, rv[15:0]);
        chk("sdo used", 64'h1, host.outOeSeen);
        chk("sdio kept input", 64'h0, host.ioOeSeen);
        rd(5'h1f, 1, 1'b0, rv);
        chk("read unmapped", 64'h0, rv[7:0]);
        chk("pins float", 64'h3, {serialDataIoOeB, serialDataOutOeB});
    endtask

    task automatic t_pump;
        for (int i = 0; i < 3; i++)
        begin
            wr(DSC_ADDR_CLKDIV, 1, 32'(i), 1'b0);
            chk("divider", 64'(i), clkDivRatio);
            chk("auto pump", 64'(i), chargePumpCode);
        end
        for (int j = 0; j < 5; j++)
        begin
            wr(DSC_ADDR_PLL, 1, 32'hc0 | 32'(j), 1'b0);
            chk("pll manual", 64'(8'hc0 | j), {pllEnable, chargePumpManual, 3'h0,
                chargePumpCode});
        end
    endtask

    // The first byte must land while the second is still being shifted.
    task automatic t_immediate;
        fork
            wr(DSC_ADDR_I_FINE, 2, 32'h1177, 1'b0);
            begin
                wait (host.bitCount == 18);
                @(posedge core_clk);
                chk("early update", 64'h77, iFineGain);
            end
        join
        chk("second byte", 64'h0, {pllEnable, chargePumpManual});
    endtask

    task automatic t_abort;
        host.xfer(8'h05, 1, 32'h99, 1'b0, 12, rv);
        chk("partial dropped", 64'h77, iFineGain);
        wr(DSC_ADDR_I_FINE, 1, 32'h42, 1'b0);
        chk("restart", 64'h42, iFineGain);
    endtask

    // LSB-first with one bidirectional line; the read wraps 1Fh up to 00h.
    task automatic t_lsb_bidir;
        wr(DSC_ADDR_SERIAL, 1, 32'hc0, 1'b0);
        rd(5'h1f, 2, 1'b1, rv);
        chk("wrap read", 64'hc000, rv[15:0]);
        chk("sdo silent", 64'h0, host.outOeSeen);
        chk("sdio drives", 64'h1, host.ioOeSeen);
        wr(DSC_ADDR_I_FINE, 1, 32'h2d, 1'b1);
        chk("lsb write", 64'h2d, iFineGain);
        wr(DSC_ADDR_Q_FINE, 2, 32'h0681, 1'b1);
        chk("lsb q fine", 64'h81, qFineGain);
        chk("lsb q coarse", 64'h6, qCoarseGain);
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial
    begin
        rst_b = 1'b0;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_reset();
        t_gain_offset();
        t_pump();
        t_immediate();
        t_abort();
        t_lsb_bidir();
        tally_and_finish();
    end

    // The sequence needs about 6400 cycles; 40000 cycles means a hang.
    initial
    begin
        #(40000 * 5);
        mismatches++;
        tally_and_finish();
    end
endmodule // tb

`default_nettype wire
